// >>> inc/secure_access_unit_map.svh
// Notes on behaviour
// - remap targets at 0x04*n in the channel window, unlock word at 0xFC
// - control bit 0 turns unit on, bit 1 off; zeros ignored
// - control bit 2 enters setup mode, bit 3 leaves it; zeros ignored
// - control bit 4 enables bus error answers, bit 5 disables them
// - configuration bit 16 one means open mode, zero means locked mode
// - unlock lasts the configured cycle count or until one channel access
// - unlock succeeds only when written key equals stored key
// - low enable bits channels 0-31, high bits channels 32-62, bit 31 unused
// - idle resets one, clears at channel access start, sets on completion
// - status bit 9 shows setup mode
// - status bit 8 shows unit enabled
// - bad target address flag when upper half not 0xFFFC..0xFFFF
// - master bus fault flag on error answer to forwarded transfer
// - unlock write while any error flag set aborts and flags
// - unlock with wrong key sets wrong key flag
// - reading the unlock word sets read attempt flag
// - access to locked or disabled channel sets failed flag
// - single access after unlock sets success flag
// - sticky flags 7..0 clear only by writing one at offset 0x20
// - unlock expiring unused sets expired flag
// - only one channel unlocked; new unlock relocks the old one
// - permitted access reissued on master port to channel target
// - interrupt request while any flag and its mask bit are set
`ifndef SECURE_ACCESS_UNIT_MAP_SVH
`define SECURE_ACCESS_UNIT_MAP_SVH

// ---------------------------------------------------------------
// peripheral bus register offsets
// ---------------------------------------------------------------
`define OFS_CONTROL_STROBES     8'h00
`define OFS_LOCK_CONFIGURATION  8'h04
`define OFS_CHANNEL_ENABLE_HIGH 8'h08
`define OFS_CHANNEL_ENABLE_LOW  8'h0C
`define OFS_ACCESS_STATUS       8'h10
`define OFS_IRQ_ENABLE_SET      8'h14
`define OFS_IRQ_ENABLE_CLEAR    8'h18
`define OFS_IRQ_MASK            8'h1C
`define OFS_STATUS_FLAG_CLEAR   8'h20
`define OFS_IMPL_PARAMETERS     8'h24
`define OFS_MODULE_REVISION     8'h28

// ---------------------------------------------------------------
// channel window and field positions
// ---------------------------------------------------------------
`define OFS_CHANNEL_UNLOCK      8'hFC
`define CHANNEL_COUNT           6'h3F
`define CTL_UNIT_ON             0
`define CTL_UNIT_OFF            1
`define CTL_SETUP_ENTER         2
`define CTL_SETUP_EXIT          3
`define CTL_BERR_ON             4
`define CTL_BERR_OFF            5
`define CFG_OPEN                16
`define CFG_UNLOCK_WINDOW_CYCLES_HI             15
`define CFG_UNLOCK_WINDOW_CYCLES_LO             8
`define CFG_UNLOCK_KEY_VALUE_HI             7
`define CFG_UNLOCK_KEY_VALUE_LO             0
`define UNL_KEY_HI              15
`define UNL_KEY_LO              8
`define UNL_CH_HI               5
`define UNL_CH_LO               0
`define ST_IDLE                 10
`define ST_SETUP                9
`define ST_ENABLED              8
`define FLAG_BAD_TARGET         7
`define FLAG_MASTER_FAULT       6
`define FLAG_UNLOCK_BLOCKED     5
`define FLAG_WRONG_KEY          4
`define FLAG_UNLOCK_READ        3
`define FLAG_ACCESS_FAILED      2
`define FLAG_ACCESS_OK          1
`define FLAG_EXPIRED            0
`define ERROR_FLAGS_MASK        8'hFD
`define TARGET_MIN_UPPER        16'hFFFC
`define ACCESS_STATUS_RESET     32'h0000_0400
`define REG_RESET               32'h0000_0000
`define MODULE_REVISION_VALUE   32'h0000_0100

`endif

// >>> inc/secure_access_unit_pkg.sv
package secure_access_unit_pkg;
   // one channel window request from the cpu side
   typedef struct packed {
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } window_req_t;

   // one forwarded transfer on the master port
   typedef struct packed {
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } master_req_t;

   typedef enum logic {
      FWD_IDLE,
      FWD_BUSY
   } fwd_state_t;
endpackage : secure_access_unit_pkg

// >>> rtl/secure_access_unit.sv
`timescale 1ns/1ns
`include "secure_access_unit_map.svh"

module secure_access_unit (
   input  wire logic                                 clk_i,
   input  wire logic                                 sys_rst_i,
   // peripheral bus register port
   input  wire logic                                 pb_sel_i,
   input  wire logic                                 pb_write_i,
   input  wire logic [7:0]                           pb_addr_i,
   input  wire logic [31:0]                          pb_wdata_i,
   output logic      [31:0]                          pb_rdata_o,
   // high speed bus channel window slave
   input  wire logic                                 win_valid_i,
   input  wire secure_access_unit_pkg::window_req_t  win_req_i,
   output logic                                      win_done_o,
   output logic      [31:0]                          win_rdata_o,
   output logic                                      win_error_o,
   // high speed bus master
   output logic                                      mst_valid_o,
   output secure_access_unit_pkg::master_req_t       mst_req_o,
   input  wire logic                                 mst_done_i,
   input  wire logic [31:0]                          mst_rdata_i,
   input  wire logic                                 mst_error_i,
   output logic                                      irq_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic                                 unit_on;
   logic                                 setup_mode;
   logic                                 berr_on;
   logic                                 open_mode;
   logic [7:0]                           unlock_window_cycles;
   logic [7:0]                           unlock_key_value;
   logic [31:0]                          channel_enable_high;
   logic [31:0]                          channel_enable_low;
   logic [7:0]                           flags;
   logic [7:0]                           irq_mask;
   logic                                 idle;
   logic [31:0]                          remap_target [0:62];
   logic                                 unlocked;
   logic [5:0]                           unlocked_ch;
   logic [7:0]                           unlock_cnt;
   secure_access_unit_pkg::fwd_state_t   fwd_state;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic        pb_wr;
   logic        pb_rd;
   logic [5:0]  win_ch;
   logic        win_is_unlock;
   logic        win_take;
   logic [62:0] ch_enabled;
   logic        ch_permitted;
   logic        unlock_wr;
   logic        unlock_rd;
   logic        setup_wr;
   logic        setup_rd;
   logic        chan_access;
   logic        fwd_start;
   logic        refused;
   logic        key_ok;
   logic        unlock_grant;
   logic        window_used;
   logic        expire;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;

   assign pb_wr         = pb_sel_i & pb_write_i;
   assign pb_rd         = pb_sel_i & ~pb_write_i;
   assign win_ch        = win_req_i.addr[7:2];
   assign win_is_unlock = (win_req_i.addr == `OFS_CHANNEL_UNLOCK);
   assign win_take      = win_valid_i & (fwd_state == secure_access_unit_pkg::FWD_IDLE);
   assign unlock_wr     = win_take & win_is_unlock & win_req_i.write;
   assign unlock_rd     = win_take & win_is_unlock & ~win_req_i.write;
   assign setup_wr      = win_take & ~win_is_unlock & setup_mode & win_req_i.write;
   assign setup_rd      = win_take & ~win_is_unlock & setup_mode & ~win_req_i.write;
   assign chan_access   = win_take & ~win_is_unlock & ~setup_mode;

   // per channel enable bits, high register bit 31 left out
   genvar g;
   generate
      for (g = 0; g < 63; g++) begin : gen_enable
         if (g < 32) begin : gen_low
            assign ch_enabled[g] = channel_enable_low[g];
         end else begin : gen_high
            assign ch_enabled[g] = channel_enable_high[g-32];
         end
      end
   endgenerate

   // open mode skips the lock; locked mode needs the one unlocked channel
   assign ch_permitted = unit_on & ch_enabled[win_ch]
                       & (open_mode | (unlocked & (unlocked_ch == win_ch)));
   assign fwd_start    = chan_access & ch_permitted;
   assign refused      = chan_access & ~ch_permitted;
   assign key_ok       = (win_req_i.wdata[`UNL_KEY_HI:`UNL_KEY_LO] == unlock_key_value);
   assign unlock_grant = unlock_wr & ((flags & `ERROR_FLAGS_MASK) == 8'h00) & key_ok;
   assign window_used  = fwd_start & ~open_mode & unlocked;
   assign expire       = unlocked & ~window_used & ~unlock_wr & (unlock_cnt <= 8'h01);

   // ---------------------------------------------------------------
   // control strobes and configuration
   // ---------------------------------------------------------------
   // write-one strobes; off wins when on and off come together
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         unit_on    <= 1'b0;
         setup_mode <= 1'b0;
         berr_on    <= 1'b0;
      end else if (pb_wr && pb_addr_i == `OFS_CONTROL_STROBES) begin
         if (pb_wdata_i[`CTL_UNIT_OFF]) begin
            unit_on <= 1'b0;
         end else if (pb_wdata_i[`CTL_UNIT_ON]) begin
            unit_on <= 1'b1;
         end
         if (pb_wdata_i[`CTL_SETUP_EXIT]) begin
            setup_mode <= 1'b0;
         end else if (pb_wdata_i[`CTL_SETUP_ENTER]) begin
            setup_mode <= 1'b1;
         end
         if (pb_wdata_i[`CTL_BERR_OFF]) begin
            berr_on <= 1'b0;
         end else if (pb_wdata_i[`CTL_BERR_ON]) begin
            berr_on <= 1'b1;
         end
      end
   end

   // lock configuration, channel enables and interrupt mask
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         open_mode            <= 1'b0;
         unlock_window_cycles <= 8'h00;
         unlock_key_value     <= 8'h00;
         channel_enable_high  <= `REG_RESET;
         channel_enable_low   <= `REG_RESET;
         irq_mask             <= 8'h00;
      end else if (pb_wr) begin
         case (pb_addr_i)
            `OFS_LOCK_CONFIGURATION: begin
               open_mode            <= pb_wdata_i[`CFG_OPEN];
               unlock_window_cycles <= pb_wdata_i[`CFG_UNLOCK_WINDOW_CYCLES_HI:`CFG_UNLOCK_WINDOW_CYCLES_LO];
               unlock_key_value     <= pb_wdata_i[`CFG_UNLOCK_KEY_VALUE_HI:`CFG_UNLOCK_KEY_VALUE_LO];
            end
            `OFS_CHANNEL_ENABLE_HIGH: channel_enable_high <= {1'b0, pb_wdata_i[30:0]};
            `OFS_CHANNEL_ENABLE_LOW:  channel_enable_low  <= pb_wdata_i;
            `OFS_IRQ_ENABLE_SET:      irq_mask <= irq_mask | pb_wdata_i[7:0];
            `OFS_IRQ_ENABLE_CLEAR:    irq_mask <= irq_mask & ~pb_wdata_i[7:0];
            default: begin
            end
         endcase
      end
   end

   // register read data, one cycle after the read
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pb_rdata_o <= `REG_RESET;
      end else if (pb_rd) begin
         case (pb_addr_i)
            `OFS_CHANNEL_ENABLE_HIGH: pb_rdata_o <= channel_enable_high;
            `OFS_CHANNEL_ENABLE_LOW:  pb_rdata_o <= channel_enable_low;
            `OFS_ACCESS_STATUS:       pb_rdata_o <= {21'h00_0000, idle, setup_mode, unit_on, flags};
            `OFS_IRQ_MASK:            pb_rdata_o <= {24'h00_0000, irq_mask};
            `OFS_IMPL_PARAMETERS:     pb_rdata_o <= {26'h000_0000, `CHANNEL_COUNT};
            `OFS_MODULE_REVISION:     pb_rdata_o <= `MODULE_REVISION_VALUE;  // arbitrary value
            default:                  pb_rdata_o <= `REG_RESET;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // remap targets
   // ---------------------------------------------------------------
   // written only in setup mode through the channel window
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 63; i++) begin
            remap_target[i] <= `REG_RESET;
         end
      end else if (setup_wr) begin
         remap_target[win_ch] <= win_req_i.wdata;
      end
   end

   // ---------------------------------------------------------------
   // unlock window
   // ---------------------------------------------------------------
   // one channel at a time; any unlock write drops the old one first
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         unlocked    <= 1'b0;
         unlocked_ch <= 6'h00;
         unlock_cnt  <= 8'h00;
      end else if (unlock_wr) begin
         unlocked    <= unlock_grant;
         unlocked_ch <= win_req_i.wdata[`UNL_CH_HI:`UNL_CH_LO];
         unlock_cnt  <= unlock_window_cycles;
      end else if (window_used || expire) begin
         unlocked <= 1'b0;
      end else if (unlocked) begin
         unlock_cnt <= unlock_cnt - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // sticky status flags
   // ---------------------------------------------------------------
   // events collected per cycle; a set in the clear cycle survives
   always_comb begin
      flag_set                       = 8'h00;
      flag_set[`FLAG_BAD_TARGET]     = setup_wr & (win_req_i.wdata[31:16] < `TARGET_MIN_UPPER);
      flag_set[`FLAG_MASTER_FAULT]   = (fwd_state == secure_access_unit_pkg::FWD_BUSY)
                                     & mst_done_i & mst_error_i;
      flag_set[`FLAG_UNLOCK_BLOCKED] = unlock_wr & ((flags & `ERROR_FLAGS_MASK) != 8'h00);
      flag_set[`FLAG_WRONG_KEY]      = unlock_wr & ((flags & `ERROR_FLAGS_MASK) == 8'h00) & ~key_ok;
      flag_set[`FLAG_UNLOCK_READ]    = unlock_rd;
      flag_set[`FLAG_ACCESS_FAILED]  = refused;
      flag_set[`FLAG_ACCESS_OK]      = window_used;
      flag_set[`FLAG_EXPIRED]        = expire;
      flag_clr                       = (pb_wr && pb_addr_i == `OFS_STATUS_FLAG_CLEAR) ? pb_wdata_i[7:0] : 8'h00;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flags <= 8'h00;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // interrupt request from flags gated by the mask
   assign irq_o = |(flags & irq_mask);

   // ---------------------------------------------------------------
   // forwarding engine
   // ---------------------------------------------------------------
   // new window requests wait while a transfer is outstanding
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fwd_state   <= secure_access_unit_pkg::FWD_IDLE;
         mst_valid_o <= 1'b0;
         mst_req_o   <= '0;
         idle        <= 1'b1;
      end else begin
         case (fwd_state)
            secure_access_unit_pkg::FWD_IDLE: begin
               if (fwd_start) begin
                  fwd_state       <= secure_access_unit_pkg::FWD_BUSY;
                  mst_valid_o     <= 1'b1;
                  mst_req_o.write <= win_req_i.write;
                  mst_req_o.addr  <= remap_target[win_ch];
                  mst_req_o.wdata <= win_req_i.wdata;
                  idle            <= 1'b0;
               end
            end
            secure_access_unit_pkg::FWD_BUSY: begin
               if (mst_done_i) begin
                  fwd_state   <= secure_access_unit_pkg::FWD_IDLE;
                  mst_valid_o <= 1'b0;
                  idle        <= 1'b1;
               end
            end
            default: begin
               fwd_state   <= secure_access_unit_pkg::FWD_IDLE;
               mst_valid_o <= 1'b0;
               idle        <= 1'b1;
            end
         endcase
      end
   end

   // answers to the channel window
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         win_done_o  <= 1'b0;
         win_rdata_o <= `REG_RESET;
         win_error_o <= 1'b0;
      end else begin
         win_done_o  <= 1'b0;
         win_error_o <= 1'b0;
         if (fwd_state == secure_access_unit_pkg::FWD_BUSY && mst_done_i) begin
            win_done_o  <= 1'b1;
            win_rdata_o <= mst_rdata_i;
            win_error_o <= mst_error_i & berr_on;
         end else if (unlock_rd || refused) begin
            win_done_o  <= 1'b1;
            win_rdata_o <= `REG_RESET;
            win_error_o <= berr_on;
         end else if (setup_rd) begin
            win_done_o  <= 1'b1;
            win_rdata_o <= remap_target[win_ch];
         end else if (win_take && !fwd_start) begin
            win_done_o  <= 1'b1;
            win_rdata_o <= `REG_RESET;
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   refused_no_fwd_a: assert property (refused |=> !mst_valid_o && $stable(idle))
      else $error("refused access started a master transfer");
   refused_flag_a: assert property (refused |=> flags[`FLAG_ACCESS_FAILED] && win_done_o)
      else $error("refused access not flagged");
   fwd_target_a: assert property (fwd_start |=> mst_valid_o && mst_req_o.addr == $past(remap_target[win_ch]))
      else $error("forwarded address differs from remap target");
   idle_track_a: assert property (mst_valid_o |-> !idle)
      else $error("idle set while transfer outstanding");
   done_idle_a: assert property (mst_valid_o && mst_done_i |=> idle && win_done_o)
      else $error("idle not restored after completion");
   fault_flag_a: assert property (mst_valid_o && mst_done_i && mst_error_i |=> flags[`FLAG_MASTER_FAULT])
      else $error("master fault not flagged");
   blocked_unlock_a: assert property (unlock_wr && (flags & `ERROR_FLAGS_MASK) != 8'h00
                                      |=> !unlocked && flags[`FLAG_UNLOCK_BLOCKED])
      else $error("unlock not aborted while error flags set");
   wrong_key_a: assert property (unlock_wr && !key_ok |=> !unlocked)
      else $error("unlock granted with wrong key");
   unlock_read_a: assert property (unlock_rd |=> flags[`FLAG_UNLOCK_READ] && win_error_o == $past(berr_on))
      else $error("unlock read not flagged");
   sticky_hold_a: assert property (flags != 8'h00 && !(pb_wr && pb_addr_i == `OFS_STATUS_FLAG_CLEAR)
                                   |=> (flags & $past(flags)) == $past(flags))
      else $error("flag cleared without clear write");
   irq_level_a: assert property (irq_o == ((flags & irq_mask) != 8'h00))
      else $error("interrupt request mismatch");
   single_use_a: assert property (window_used |=> !unlocked && flags[`FLAG_ACCESS_OK])
      else $error("unlock survived its access");

   fwd_cover_c: cover property (fwd_start ##[1:20] mst_done_i);
   unlock_use_c: cover property (unlock_grant ##[1:20] window_used);
   expire_c: cover property (unlock_grant ##[1:300] expire);
   refuse_c: cover property (refused && berr_on);

endmodule : secure_access_unit

// >>> test/protected_slave_model.sv
`timescale 1ns/1ns

module protected_slave_model #(
   parameter logic [31:0] FAULT_ADDR = 32'hFFFD_0004
) (
   input  wire logic                                  clk_i,
   input  wire logic                                  sys_rst_i,
   input  wire logic                                  mst_valid_i,
   input  wire secure_access_unit_pkg::master_req_t   mst_req_i,
   output logic                                       mst_done_o,
   output logic      [31:0]                           mst_rdata_o,
   output logic                                       mst_error_o,
   output logic      [7:0]                            xfer_count_o,
   output logic      [31:0]                           last_addr_o,
   output logic      [31:0]                           last_wdata_o
);
   logic [2:0] wait_cnt;

   // answers fast, or six cycles later when address bit 2 is set; one fault address
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wait_cnt     <= 3'h0;
         mst_done_o   <= 1'b0;
         mst_error_o  <= 1'b0;
         mst_rdata_o  <= 32'h5555_5555;
         xfer_count_o <= 8'h00;
      end else if (mst_valid_i && !mst_done_o && wait_cnt == {mst_req_i.addr[2], 2'b11}) begin
         wait_cnt     <= 3'h0;
         mst_done_o   <= 1'b1;
         mst_error_o  <= (mst_req_i.addr == FAULT_ADDR);
         mst_rdata_o  <= ~mst_req_i.addr;
         xfer_count_o <= xfer_count_o + 8'h01;
         last_addr_o  <= mst_req_i.addr;
         last_wdata_o <= mst_req_i.wdata;
      end else begin
         wait_cnt     <= (mst_valid_i && !mst_done_o) ? wait_cnt + 3'h1 : {1'b0, ~mst_req_i.addr[2], 1'b0};
         mst_done_o   <= 1'b0;
         mst_error_o  <= ~mst_error_o;
         mst_rdata_o  <= ~mst_rdata_o; // released data toggles
      end
   end
endmodule : protected_slave_model

// >>> test/secure_access_unit_test.sv
`timescale 1ns/1ns
`define CHECK(name, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", name, exp, got); end end

module secure_access_unit_test;
   logic                                clk_i, sys_rst_i, pb_sel_i, pb_write_i, win_valid_i;
   logic                                mst_valid_o, mst_done_i, mst_error_i, irq_o;
   logic                                win_done_o, win_error_o;
   logic [7:0]                          pb_addr_i, xfer_count;
   logic [31:0]                         pb_wdata_i, pb_rdata_o, win_rdata_o, mst_rdata_i;
   logic [31:0]                         last_addr, last_wdata;
   secure_access_unit_pkg::window_req_t win_req_i;
   secure_access_unit_pkg::master_req_t mst_req_o;
   int                                  fails, checks;

   secure_access_unit i_secure_access_unit (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pb_sel_i(pb_sel_i),
      .pb_write_i(pb_write_i), .pb_addr_i(pb_addr_i), .pb_wdata_i(pb_wdata_i), .pb_rdata_o(pb_rdata_o),
      .win_valid_i(win_valid_i), .win_req_i(win_req_i), .win_done_o(win_done_o), .win_rdata_o(win_rdata_o),
      .win_error_o(win_error_o), .mst_valid_o(mst_valid_o), .mst_req_o(mst_req_o), .mst_done_i(mst_done_i),
      .mst_rdata_i(mst_rdata_i), .mst_error_i(mst_error_i), .irq_o(irq_o));

   protected_slave_model i_protected_slave_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .mst_valid_i(mst_valid_o), .mst_req_i(mst_req_o), .mst_done_o(mst_done_i), .mst_rdata_o(mst_rdata_i),
      .mst_error_o(mst_error_i), .xfer_count_o(xfer_count), .last_addr_o(last_addr), .last_wdata_o(last_wdata));

   // --------------------------------------------------------
   // clock and closing report
   // --------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   // --------------------------------------------------------
   // register port and channel window access
   // --------------------------------------------------------
   task automatic pb_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      pb_sel_i   <= 1'b1;
      pb_write_i <= 1'b1;
      pb_addr_i  <= a;
      pb_wdata_i <= d;
      @(posedge clk_i);
      pb_sel_i   <= 1'b0;
   endtask : pb_wr

   task automatic pb_rd(input string nm, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      @(posedge clk_i);
      pb_sel_i   <= 1'b1;
      pb_write_i <= 1'b0;
      pb_addr_i  <= a;
      @(posedge clk_i);
      pb_sel_i   <= 1'b0;
      #1 `CHECK(nm, exp, pb_rdata_o & mask)
   endtask : pb_rd

   // exp_err 2 means the error answer is not judged
   task automatic win(input logic w, input logic [7:0] a, input logic [31:0] d, input int exp_err);
      int n;
      @(posedge clk_i);
      win_valid_i <= 1'b1;
      win_req_i   <= '{write: w, addr: a, wdata: d};
      @(posedge clk_i);
      win_valid_i <= 1'b0;
      for (n = 0; n < 40; n++) begin
         #1 if (win_done_o === 1'b1) break;
         @(posedge clk_i);
      end
      if (n == 40) begin
         fails++;
         $display("ERROR win_done expected 1 seen 0");
         test_done();
      end
      if (exp_err < 2) `CHECK("win_error", exp_err[0], win_error_o)
   endtask : win

   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      {sys_rst_i, pb_sel_i, pb_write_i, win_valid_i} = 4'h8;
      {pb_addr_i, pb_wdata_i, win_req_i} = '0;
      fails = 0;
      checks = 0;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      pb_rd("status reset", 8'h10, 32'hFFFF_FFFF, 32'h0000_0400);
      pb_wr(8'h00, 32'h0000_0001);
      pb_wr(8'h00, 32'h0000_0000);
      pb_rd("unit on", 8'h10, 32'hFFFF_FFFF, 32'h0000_0500);
      $display("test reset and control done");
      pb_wr(8'h00, 32'h0000_0004);
      win(1'b1, 8'h00, 32'hFFFC_0010, 0);
      win(1'b1, 8'h08, 32'hFFFD_0004, 0);
      win(1'b1, 8'h04, 32'h1234_0000, 2);
      win(1'b0, 8'h00, 32'h0000_0000, 0);
      `CHECK("target readback", 32'hFFFC_0010, win_rdata_o)
      pb_rd("setup status", 8'h10, 32'hFFFF_FFFF, 32'h0000_0780);
      `CHECK("no forward in setup", 8'h00, xfer_count)
      pb_wr(8'h00, 32'h0000_0008);
      pb_wr(8'h20, 32'h0000_00FF);
      pb_rd("setup left", 8'h10, 32'hFFFF_FFFF, 32'h0000_0500);
      $display("test setup done");
      pb_wr(8'h0C, 32'h0000_0005);
      pb_wr(8'h08, 32'h0000_0001);
      pb_rd("enable low", 8'h0C, 32'hFFFF_FFFF, 32'h0000_0005);
      pb_rd("enable high", 8'h08, 32'h7FFF_FFFF, 32'h0000_0001);
      pb_wr(8'h04, 32'h0001_0000);
      win(1'b1, 8'h00, 32'hA5A5_0001, 0);
      `CHECK("fwd addr", 32'hFFFC_0010, last_addr)
      `CHECK("fwd data", 32'hA5A5_0001, last_wdata)
      win(1'b0, 8'h00, 32'h0000_0000, 0);
      `CHECK("fwd read", 32'h0003_FFEF, win_rdata_o)
      pb_rd("idle after", 8'h10, 32'h0000_0400, 32'h0000_0400);
      win(1'b0, 8'h04, 32'h0000_0000, 0);
      `CHECK("refused no xfer", 8'h02, xfer_count)
      pb_wr(8'h00, 32'h0000_0010);
      win(1'b0, 8'h04, 32'h0000_0000, 1);
      win(1'b0, 8'h08, 32'h0000_0000, 1);
      pb_rd("faults", 8'h10, 32'h0000_0044, 32'h0000_0044);
      $display("test open mode done");
      pb_wr(8'h20, 32'h0000_00FF);
      pb_wr(8'h14, 32'h0000_0040);
      pb_rd("mask", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0040);
      `CHECK("irq quiet", 1'b0, irq_o)
      win(1'b0, 8'h08, 32'h0000_0000, 1);
      `CHECK("irq raised", 1'b1, irq_o)
      pb_wr(8'h18, 32'h0000_0040);
      #1 `CHECK("irq masked", 1'b0, irq_o)
      pb_wr(8'h20, 32'h0000_00FF);
      $display("test interrupt done");
      pb_wr(8'h04, 32'h0000_045A);
      win(1'b1, 8'h00, 32'h0000_0001, 1);
      win(1'b1, 8'hFC, 32'h0000_5A00, 2);
      pb_rd("blocked", 8'h10, 32'h0000_00FF, 32'h0000_0024);
      pb_wr(8'h20, 32'h0000_00FF);
      win(1'b1, 8'hFC, 32'h0000_5B00, 2);
      pb_rd("bad key", 8'h10, 32'h0000_00FF, 32'h0000_0010);
      pb_wr(8'h20, 32'h0000_00FF);
      win(1'b1, 8'hFC, 32'h0000_5A00, 0);
      win(1'b1, 8'h00, 32'h0000_0002, 0);
      win(1'b1, 8'h00, 32'h0000_0003, 1);
      pb_rd("one use", 8'h10, 32'h0000_00FF, 32'h0000_0006);
      pb_wr(8'h20, 32'h0000_00FF);
      win(1'b1, 8'hFC, 32'h0000_5A00, 0);
      repeat (8) @(posedge clk_i);
      win(1'b1, 8'h00, 32'h0000_0004, 1);
      pb_rd("expired", 8'h10, 32'h0000_00FF, 32'h0000_0005);
      pb_wr(8'h20, 32'h0000_00FF);
      win(1'b1, 8'hFC, 32'h0000_5A00, 0);
      win(1'b1, 8'hFC, 32'h0000_5A02, 0);
      win(1'b1, 8'h00, 32'h0000_0005, 1);
      win(1'b0, 8'hFC, 32'h0000_0000, 1);
      pb_rd("unlock read", 8'h10, 32'h0000_000C, 32'h0000_000C);
      `CHECK("locked xfers", 8'h05, xfer_count)
      $display("test locked mode done");
      pb_rd("idle before off", 8'h10, 32'h0000_0400, 32'h0000_0400);
      pb_wr(8'h00, 32'h0000_0002);
      pb_rd("unit off", 8'h10, 32'h0000_0100, 32'h0000_0000);
      pb_wr(8'h00, 32'h0000_0020);
      win(1'b0, 8'h04, 32'h0000_0000, 0);
      pb_rd("channels", 8'h24, 32'hFFFF_FFFF, 32'h0000_003F);
      $display("test disable done");
      test_done();
   end
endmodule : secure_access_unit_test
